// ---- common/cerb_mem_if.sv ----
/*
 Two-port array access bundle between the block controller and its storage array.
 Assumes both ends run on the same pclk.
*/
`default_nettype none
interface cerb_mem_if;
   import cerb_pkg::*;
   logic [1:0] en;
   logic [1:0] we;
   logic [CERB_AW-1:0] addr [2];
   logic [CERB_DW-1:0] wdata [2];
   logic [CERB_LANES-1:0] be [2];
   logic [CERB_DW-1:0] rdata [2];
   modport ctl (output en, we, addr, wdata, be, input rdata);
   modport mem (input en, we, addr, wdata, be, output rdata);
endinterface
`default_nettype wire

// ---- common/cerb_pkg.sv ----
/*
 Constants, register map and types shared by the configurable embedded RAM block.
 Assumes a single pclk domain and an APB register bus with 32-bit data.
*/
`default_nettype none
package cerb_pkg;
   localparam int CERB_AW = 7;
   localparam int CERB_DW = 36;
   localparam int CERB_LANES = 4;
   localparam int CERB_LW = 9;
   localparam int CERB_NGRP = 5;
   localparam int CERB_PADDR_W = 8;
   // Small variant: 32 x 18, medium variant: 128 x 36
   localparam int CERB_SMALL_DEPTH = 32;
   localparam int CERB_SMALL_AW = 5;
   localparam int CERB_SMALL_LANES = 2;
   localparam int CERB_MED_DEPTH = 128;
   localparam logic [15:0] CERB_SMALL_BITS = 16'h0240;
   localparam logic [15:0] CERB_MED_BITS = 16'h1200;
   // Register byte offsets
   localparam logic [7:0] CERB_CTRL_OFF = 8'h00;
   localparam logic [7:0] CERB_A_ADDR_OFF = 8'h04;
   localparam logic [7:0] CERB_A_WDATA_OFF = 8'h08;
   localparam logic [7:0] CERB_A_CTL_OFF = 8'h0c;
   localparam logic [7:0] CERB_B_ADDR_OFF = 8'h10;
   localparam logic [7:0] CERB_B_WDATA_OFF = 8'h14;
   localparam logic [7:0] CERB_B_CTL_OFF = 8'h18;
   localparam logic [7:0] CERB_CMD_OFF = 8'h1c;
   localparam logic [7:0] CERB_A_DOUT_OFF = 8'h20;
   localparam logic [7:0] CERB_B_DOUT_OFF = 8'h24;
   localparam logic [7:0] CERB_DPAR_OFF = 8'h28;
   localparam logic [7:0] CERB_STATUS_OFF = 8'h2c;
   localparam int CERB_PORT_STRIDE = 3;
   // CTRL fields
   localparam int CERB_CTRL_VAR = 0;
   localparam int CERB_CTRL_BYP = 1;
   localparam int CERB_CTRL_CSEL = 4;
   localparam int CERB_CTRL_CE = 14;
   localparam logic [31:0] CERB_CTRL_RST = 32'h0000_c000;
   // Clock-select group index inside each port's field
   localparam int CERB_GRP_RW = 0;
   localparam int CERB_GRP_ADDR = 1;
   localparam int CERB_GRP_BE = 2;
   localparam int CERB_GRP_DATA = 3;
   localparam int CERB_GRP_OUT = 4;
   // Port CTL fields
   localparam int CERB_CTL_PAR = 0;
   localparam int CERB_CTL_BE = 4;
   localparam int CERB_CTL_RW = 8;
   localparam int CERB_CTL_RDEN = 9;
   // CMD fields
   localparam int CERB_CMD_TICK = 0;
   localparam int CERB_CMD_CLRIN = 2;
   localparam int CERB_CMD_CLROUT = 4;
   localparam int CERB_CMD_PRELOAD = 6;
   // STATUS fields, then the port B parity position in DPAR
   localparam int CERB_ST_BUSY = 0;
   localparam int CERB_ST_VAR = 1;
   localparam int CERB_ST_CAP = 16;
   localparam int CERB_DPAR_B = 4;
   typedef enum logic {CERB_SMALL, CERB_MEDIUM} cerb_variant_t;
   typedef enum logic {CERB_PL_IDLE, CERB_PL_RUN} cerb_pl_state_t;
endpackage
`default_nettype wire

// ---- core/cerb_mem.sv ----
/*
 Dual-port storage array, 128 words of four 9-bit lanes, registered read data.
 Assumes en, we, addr, wdata and be are registered by the controller.
*/
`default_nettype none
module cerb_mem (
   // Clock
   input wire logic pclk,
   // Array ports
   cerb_mem_if.mem m
);
   import cerb_pkg::*;
   logic [CERB_DW-1:0] store [CERB_MED_DEPTH];

   for (genvar p = 0; p < 2; p++) begin : g_port
      // Read returns the old word when the same port writes
      always_ff @(posedge pclk) begin
         if (m.en[p]) begin
            m.rdata[p] <= store[m.addr[p]];
         end
      end
   end

   // One process owns the array, so both ports' lane writes share a single driver
   always_ff @(posedge pclk) begin
      for (int l = 0; l < CERB_LANES; l++) begin
         if (m.en[0] && m.we[0] && m.be[0][l]) begin
            store[m.addr[0]][l*CERB_LW +: CERB_LW] <= m.wdata[0][l*CERB_LW +: CERB_LW];
         end
         if (m.en[1] && m.we[1] && m.be[1][l]) begin
            store[m.addr[1]][l*CERB_LW +: CERB_LW] <= m.wdata[1][l*CERB_LW +: CERB_LW];
         end
      end
   end
endmodule
`default_nettype wire

// ---- core/cerb_top.sv ----
/*
 Configurable embedded RAM block with APB access to its user-side pins.
 Software stages each port's inputs, fires the two block clocks as ticks,
 applies clears, and reads back the data outputs. Assumes one pclk domain.
*/
// Notes on behaviour
// RULE1 - Input register clear empties input registers immediately, no clock tick needed.
// RULE2 - After input clear, data output stays until the next active clock tick.
// RULE3 - Output register clear zeroes the output register, visible at once.
// RULE4 - Large variant cannot be preloaded; only small and medium are built here.
// RULE5 - User logic writes a large ROM once, then keeps write enables low.
// RULE6 - Small variant holds 576 bits including parity.
// RULE7 - Small variant: one write port, one read port, no true dual-port.
// RULE8 - Small variant write strobe, data and address share one clock.
// RULE9 - Small variant read address, read strobe and output pick either clock.
// RULE10 - Input registers always used; only output register can be bypassed.
// RULE11 - Small and medium contents preload from an initialization image.
// RULE12 - Small controls: input clock, output clock, write, read, output clear.
// RULE13 - Medium variant holds 4608 bits including parity.
// RULE14 - Medium variant has two independent read/write ports.
// RULE15 - Medium rw, address, byte enable, data, output pick either clock.
// RULE16 - Each medium port has own clock, rw select, clear, clock enable.
// RULE17 - Port registers hold on clock ticks while its clock enable is low.
`default_nettype none
module cerb_top #(
   parameter logic [cerb_pkg::CERB_DW-1:0] INIT_SEED = 36'h0_0000_0000,
   parameter logic [cerb_pkg::CERB_DW-1:0] INIT_STEP = 36'h0_0000_0001
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cerb_pkg::CERB_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import cerb_pkg::*;

   cerb_mem_if mi ();
   cerb_mem u_mem (
      .pclk(pclk),
      .m(mi.mem)
   );

   logic [31:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [CERB_AW-1:0] st_addr_reg [2];
   logic [31:0] st_data_reg [2];
   logic [9:0] st_ctl_reg [2];
   logic [CERB_DW-1:0] dout_reg [2];
   cerb_pl_state_t pl_state_reg;
   logic [CERB_AW-1:0] pl_addr_reg;

   logic wr_en;
   logic [7:0] off;
   logic [6:0] cmd;
   logic [1:0] tick;
   logic [1:0] clr_in;
   logic [1:0] clr_out;
   logic [1:0] acc;
   cerb_variant_t variant;
   logic [CERB_AW-1:0] last_addr;
   logic preloading;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   assign off = paddr;
   assign wr_en = psel & penable & pready_reg & pwrite;
   assign cmd = (wr_en && off == CERB_CMD_OFF) ? pwdata[6:0] : 7'h00;
   assign tick = cmd[CERB_CMD_TICK +: 2];
   assign clr_in = cmd[CERB_CMD_CLRIN +: 2];
   assign clr_out = cmd[CERB_CMD_CLROUT +: 2];
   assign variant = cerb_variant_t'(ctrl_reg[CERB_CTRL_VAR]);
   assign preloading = (pl_state_reg == CERB_PL_RUN);
   // Preload sweeps the depth of the selected variant
   assign last_addr = (variant == CERB_SMALL) ? CERB_AW'(CERB_SMALL_DEPTH - 1) : // RULE6
      CERB_AW'(CERB_MED_DEPTH - 1); // RULE13

   function automatic logic [CERB_DW-1:0] pack_word(input logic [31:0] d,
                                                  input logic [3:0] par);
      logic [CERB_DW-1:0] w;
      w = '0;
      for (int l = 0; l < CERB_LANES; l++) begin
         w[l*CERB_LW +: CERB_LW] = {par[l], d[l*8 +: 8]};
      end
      return w;
   endfunction

   function automatic logic [31:0] word_data(input logic [CERB_DW-1:0] w);
      logic [31:0] d;
      d = '0;
      for (int l = 0; l < CERB_LANES; l++) begin
         d[l*8 +: 8] = w[l*CERB_LW +: 8];
      end
      return d;
   endfunction

   function automatic logic [3:0] word_par(input logic [CERB_DW-1:0] w);
      logic [3:0] p;
      p = '0;
      for (int l = 0; l < CERB_LANES; l++) begin
         p[l] = w[l*CERB_LW + 8];
      end
      return p;
   endfunction

   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CERB_CTRL_RST;
      end else if (wr_en && off == CERB_CTRL_OFF) begin
         ctrl_reg <= pwdata;
      end
   end

   // Preload sequencer writes the image through port A
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pl_state_reg <= CERB_PL_RUN;
         pl_addr_reg <= '0;
      end else begin
         case (pl_state_reg)
            CERB_PL_IDLE: begin
               if (cmd[CERB_CMD_PRELOAD]) begin
                  pl_state_reg <= CERB_PL_RUN; // RULE11
                  pl_addr_reg <= '0;
               end
            end
            CERB_PL_RUN: begin
               if (pl_addr_reg == last_addr) begin
                  pl_state_reg <= CERB_PL_IDLE;
               end
               pl_addr_reg <= pl_addr_reg + 1'b1;
            end
            default: begin
               pl_state_reg <= CERB_PL_IDLE;
            end
         endcase
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_port
      logic [CERB_NGRP-1:0] csel;
      logic [CERB_NGRP-1:0] fire;
      logic ce;
      logic byp;
      logic rw_reg;
      logic rden_reg;
      logic [CERB_AW-1:0] addr_reg;
      logic [CERB_LANES-1:0] be_reg;
      logic [CERB_DW-1:0] data_reg;
      logic acc_reg;
      logic [CERB_LANES-1:0] be_eff;
      logic [CERB_AW-1:0] addr_eff;

      assign ce = ctrl_reg[CERB_CTRL_CE + p]; // RULE16
      assign byp = ctrl_reg[CERB_CTRL_BYP + p]; // RULE10
      always_comb begin
         csel = ctrl_reg[CERB_CTRL_CSEL + p*CERB_NGRP +: CERB_NGRP]; // RULE9 RULE15
         if (variant == CERB_SMALL && p == 0) begin
            // Write side of the small variant runs on one clock
            csel[CERB_GRP_RW] = csel[CERB_GRP_ADDR]; // RULE8
            csel[CERB_GRP_BE] = csel[CERB_GRP_ADDR]; // RULE8
            csel[CERB_GRP_DATA] = csel[CERB_GRP_ADDR]; // RULE8
         end
         for (int g = 0; g < CERB_NGRP; g++) begin
            fire[g] = tick[csel[g]] & ce; // RULE17
         end
      end

      // Staged user-side pins
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            st_addr_reg[p] <= '0;
            st_data_reg[p] <= '0;
            st_ctl_reg[p] <= '0;
         end else if (wr_en) begin
            if (off == CERB_A_ADDR_OFF + 8'(p*4*CERB_PORT_STRIDE)) begin
               st_addr_reg[p] <= pwdata[CERB_AW-1:0];
            end
            if (off == CERB_A_WDATA_OFF + 8'(p*4*CERB_PORT_STRIDE)) begin
               st_data_reg[p] <= pwdata;
            end
            if (off == CERB_A_CTL_OFF + 8'(p*4*CERB_PORT_STRIDE)) begin
               st_ctl_reg[p] <= pwdata[9:0];
            end
         end
      end

      // Input registers: clear acts without a tick and wins over capture
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rw_reg <= 1'b0;
            rden_reg <= 1'b0;
            addr_reg <= '0;
            be_reg <= '0;
            data_reg <= '0;
            acc_reg <= 1'b0;
         end else if (clr_in[p]) begin
            rw_reg <= 1'b0; // RULE1
            rden_reg <= 1'b0;
            addr_reg <= '0;
            be_reg <= '0;
            data_reg <= '0;
            acc_reg <= 1'b0; // RULE2
         end else begin
            if (fire[CERB_GRP_RW]) begin
               rw_reg <= st_ctl_reg[p][CERB_CTL_RW];
               rden_reg <= st_ctl_reg[p][CERB_CTL_RDEN];
            end
            if (fire[CERB_GRP_ADDR]) begin
               addr_reg <= st_addr_reg[p];
            end
            if (fire[CERB_GRP_BE]) begin
               be_reg <= st_ctl_reg[p][CERB_CTL_BE +: CERB_LANES];
            end
            if (fire[CERB_GRP_DATA]) begin
               data_reg <= pack_word(st_data_reg[p], st_ctl_reg[p][CERB_CTL_PAR +: 4]);
            end
            acc_reg <= fire[CERB_GRP_ADDR];
         end
      end

      // Small variant: port A only writes, port B only reads under its strobe
      always_comb begin
         be_eff = be_reg;
         addr_eff = addr_reg;
         if (variant == CERB_SMALL) begin
            be_eff[CERB_LANES-1:CERB_SMALL_LANES] = '0; // RULE6
            addr_eff[CERB_AW-1:CERB_SMALL_AW] = '0;
         end
         if (variant == CERB_SMALL && p == 0) begin
            acc[p] = acc_reg & rw_reg; // RULE7
         end else if (variant == CERB_SMALL) begin
            acc[p] = acc_reg & rden_reg; // RULE7 RULE12
         end else begin
            acc[p] = acc_reg; // RULE14
         end
      end

      if (p == 0) begin : g_a
         always_comb begin
            if (preloading) begin
               mi.en[0] = 1'b1;
               mi.we[0] = 1'b1;
               mi.addr[0] = pl_addr_reg;
               mi.wdata[0] = INIT_SEED + CERB_DW'(pl_addr_reg) * INIT_STEP; // RULE4 RULE11
               mi.be[0] = '1;
            end else begin
               mi.en[0] = acc[0];
               mi.we[0] = rw_reg;
               mi.addr[0] = addr_eff;
               mi.wdata[0] = data_reg;
               mi.be[0] = be_eff;
            end
         end
      end else begin : g_b
         always_comb begin
            mi.en[1] = acc[1] & ~preloading;
            mi.we[1] = rw_reg & (variant == CERB_MEDIUM); // RULE7 RULE14
            mi.addr[1] = addr_eff;
            mi.wdata[1] = data_reg;
            mi.be[1] = be_eff;
         end
      end

      // Output register: clear shows at once, capture on its own clock tick
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dout_reg[p] <= '0;
         end else if (clr_out[p]) begin
            dout_reg[p] <= '0; // RULE3
         end else if (fire[CERB_GRP_OUT]) begin
            dout_reg[p] <= byp ? dout_reg[p] : mi.rdata[p]; // RULE10
         end
      end
   end

   // Data output as seen by user logic, through the output register or not
   logic [CERB_DW-1:0] dout_a;
   logic [CERB_DW-1:0] dout_b;
   assign dout_a = ctrl_reg[CERB_CTRL_BYP] ? mi.rdata[0] : dout_reg[0];
   assign dout_b = ctrl_reg[CERB_CTRL_BYP + 1] ? mi.rdata[1] : dout_reg[1];

   // APB: no wait states, read data sampled in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= psel & ~penable;
         pslverr_reg <= 1'b0;
         if (psel && !penable) begin
            prdata_reg <= '0;
            case (off)
               CERB_CTRL_OFF: prdata_reg <= pwrite ? '0 : ctrl_reg;
               CERB_A_ADDR_OFF: prdata_reg <= 32'(st_addr_reg[0]);
               CERB_A_WDATA_OFF: prdata_reg <= st_data_reg[0];
               CERB_A_CTL_OFF: prdata_reg <= 32'(st_ctl_reg[0]);
               CERB_B_ADDR_OFF: prdata_reg <= 32'(st_addr_reg[1]);
               CERB_B_WDATA_OFF: prdata_reg <= st_data_reg[1];
               CERB_B_CTL_OFF: prdata_reg <= 32'(st_ctl_reg[1]);
               CERB_CMD_OFF: prdata_reg <= '0;
               CERB_A_DOUT_OFF: prdata_reg <= word_data(dout_a);
               CERB_B_DOUT_OFF: prdata_reg <= word_data(dout_b);
               CERB_DPAR_OFF: begin
                  prdata_reg <= 32'({word_par(dout_b), word_par(dout_a)});
               end
               CERB_STATUS_OFF: begin
                  prdata_reg[CERB_ST_BUSY] <= preloading;
                  prdata_reg[CERB_ST_VAR] <= variant;
                  prdata_reg[CERB_ST_CAP +: 16] <= (variant == CERB_SMALL) ?
                     CERB_SMALL_BITS : CERB_MED_BITS;
               end
               default: pslverr_reg <= 1'b1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/cerb_apb_model.sv ----
/* APB master standing in for the user logic that drives the RAM block.
   Assumes the slave answers within 32 cycles; otherwise it raises hung. */
`default_nettype none
module cerb_apb_model (
   // Clock
   input wire logic pclk,
   // APB request
   output var logic psel,
   output var logic penable,
   output var logic pwrite,
   output var logic [cerb_pkg::CERB_PADDR_W-1:0] paddr,
   output var logic [31:0] pwdata,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Wait limit ran out
   output var logic hung
);
   import cerb_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hung = 1'b0;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 32);
      if (pready !== 1'b1) begin
         hung <= 1'b1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle bus carries junk, not the last request
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule
`default_nettype wire

// ---- verif/cerb_props.sv ----
/* Concurrent checks on the RAM block's APB port and status word.
   Sees only the top module's ports and is bound to it below. */
`default_nettype none
module cerb_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cerb_pkg::CERB_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import cerb_pkg::*;
   logic rd_ok;
   assign rd_ok = pready && !pwrite && !pslverr;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
      else $error("no answer in the access cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("answer outside an access cycle");
   a_err_needs_ready: assert property (pslverr |-> pready)
      else $error("error flag without answer");
   a_ready_single: assert property (pready |=> !pready)
      else $error("answer held too long");
   a_small_capacity: assert property (
      rd_ok && paddr == CERB_STATUS_OFF && !prdata[CERB_ST_VAR]
      |-> prdata[31:16] == CERB_SMALL_BITS)
      else $error("small capacity wrong");
   a_medium_capacity: assert property (
      rd_ok && paddr == CERB_STATUS_OFF && prdata[CERB_ST_VAR]
      |-> prdata[31:16] == CERB_MED_BITS)
      else $error("medium capacity wrong");
   a_cmd_reads_zero: assert property (pready && !pwrite && paddr == CERB_CMD_OFF
      |-> prdata == 32'h0 && !pslverr)
      else $error("command word not read as zero");
   a_unmapped_error: assert property (pready && paddr > CERB_STATUS_OFF
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_read_data_held: assert property (!psel |=> $stable(prdata))
      else $error("read data moved while idle");
endmodule
bind cerb_top cerb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ---- verif/tb_top.sv ----
/* Self-checking bench: register accesses drive both block ports through APB.
   Assumes the preload image word i is 0x11 + i. */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cerb_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, hung;
   logic [CERB_PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   int miscompares = 0;
   int total_checks = 0;
   always #2 pclk = ~pclk;
   cerb_top #(.INIT_SEED(36'h0_0000_0011), .INIT_STEP(36'h0_0000_0001)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cerb_apb_model apb (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hung(hung));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb.xfer(1'b1, a, d, r, e);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb.xfer(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask
   // Command write, then a spare read so the array access lands first
   task automatic tick(input logic [31:0] cmd);
      logic [31:0] r;
      logic e;
      wr(CERB_CMD_OFF, cmd);
      apb.xfer(1'b0, CERB_CTRL_OFF, 32'h0, r, e);
   endtask
   task automatic wait_idle();
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb.xfer(1'b0, CERB_STATUS_OFF, 32'h0, r, e);
         n++;
      end while (r[CERB_ST_BUSY] !== 1'b0 && n < 200);
      if (r[CERB_ST_BUSY] !== 1'b0) begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic wrport(input logic p, input logic [31:0] a, input logic [31:0] d,
         input logic [31:0] c, input logic [31:0] tk);
      wr(p ? CERB_B_ADDR_OFF : CERB_A_ADDR_OFF, a);
      wr(p ? CERB_B_WDATA_OFF : CERB_A_WDATA_OFF, d);
      wr(p ? CERB_B_CTL_OFF : CERB_A_CTL_OFF, c);
      tick(tk);
      wr(p ? CERB_B_CTL_OFF : CERB_A_CTL_OFF, 32'h0);
   endtask
   // Read strobe, one tick into the array register, one into the output register
   task automatic rdport(input logic p, input logic [31:0] a, input logic [31:0] exp,
         input logic [31:0] tk);
      wr(p ? CERB_B_ADDR_OFF : CERB_A_ADDR_OFF, a);
      wr(p ? CERB_B_CTL_OFF : CERB_A_CTL_OFF, 32'h200);
      tick(tk);
      tick(tk);
      rchk(p ? CERB_B_DOUT_OFF : CERB_A_DOUT_OFF, exp);
   endtask
   always @(posedge hung) begin
      miscompares++;
      end_of_test();
   end
   initial begin
      logic [31:0] r;
      logic e;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_idle();
      rchk(CERB_CTRL_OFF, CERB_CTRL_RST);
      rchk(CERB_STATUS_OFF, 32'h0240_0000);
      $display("reset values done");
      for (int i = 0; i < 32; i += 31) begin
         rdport(1'b1, i, 32'h11 + i, 32'h1);
      end
      $display("small preload done");
      wr(CERB_CTRL_OFF, 32'h0000_c020);
      wrport(1'b0, 32'h3, 32'h5a5a_a5c3, 32'h1f0, 32'h1);
      rdport(1'b1, 32'h3, 32'h14, 32'h1);
      wrport(1'b0, 32'h3, 32'h5a5a_a5c3, 32'h1f0, 32'h2);
      rdport(1'b1, 32'h3, 32'ha5c3, 32'h1);
      wrport(1'b1, 32'h3, 32'h1111, 32'h1f0, 32'h1);
      rdport(1'b1, 32'h3, 32'ha5c3, 32'h1);
      wr(CERB_CTRL_OFF, 32'h0000_e400);
      rdport(1'b1, 32'h5, 32'h16, 32'h2);
      $display("small ports done");
      wr(CERB_CTRL_OFF, 32'h0000_c001);
      tick(32'h40);
      wait_idle();
      rchk(CERB_STATUS_OFF, 32'h1200_0002);
      wrport(1'b1, 32'h64, 32'h1234_5678, 32'h1f5, 32'h1);
      rdport(1'b0, 32'h64, 32'h1234_5678, 32'h1);
      rchk(CERB_DPAR_OFF, 32'h55);
      wrport(1'b0, 32'h64, 32'hffff_ffff, 32'h110, 32'h1);
      rdport(1'b1, 32'h64, 32'h1234_56ff, 32'h1);
      // Port A data group on clock1: capture data, clear inputs, then write on clock0
      wr(CERB_CTRL_OFF, 32'h0000_c081);
      wr(CERB_A_ADDR_OFF, 32'h9);
      wr(CERB_A_WDATA_OFF, 32'hcafe_f00d);
      wr(CERB_A_CTL_OFF, 32'h1f0);
      tick(32'h2);
      tick(32'h4);
      tick(32'h1);
      rdport(1'b1, 32'h9, 32'h0, 32'h1);
      $display("medium ports done");
      wr(CERB_CTRL_OFF, 32'h0000_8001);
      wrport(1'b0, 32'h7, 32'hdead_beef, 32'h1f0, 32'h1);
      rdport(1'b1, 32'h7, 32'h18, 32'h1);
      $display("clock enable done");
      tick(32'h08);
      rchk(CERB_B_DOUT_OFF, 32'h18);
      tick(32'h20);
      rchk(CERB_B_DOUT_OFF, 32'h0);
      $display("clears done");
      wr(CERB_CTRL_OFF, 32'h0000_c005);
      wr(CERB_B_ADDR_OFF, 32'h64);
      wr(CERB_B_CTL_OFF, 32'h200);
      tick(32'h1);
      rchk(CERB_B_DOUT_OFF, 32'h1234_56ff);
      $display("bypass done");
      apb.xfer(1'b0, 8'h30, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
      wr(CERB_STATUS_OFF, 32'hffff_ffff);
      rchk(CERB_STATUS_OFF, 32'h1200_0003 - 32'h1);
      rchk(CERB_CMD_OFF, 32'h0);
      $display("refusals done");
      end_of_test();
   end
endmodule
`default_nettype wire
